// file: udc_pkg.sv
// udc_pkg: constants and carrier types of the 8-bit up/down counter
// assumes a 32-bit classic wishbone bus and one 10 MHz clock
package udc_pkg;
	localparam int         UDC_WIDTH       = 8;
	localparam logic [7:0] UDC_TERM_UP     = 8'hff;
	localparam logic [7:0] UDC_TERM_DOWN   = 8'h00;
	localparam logic [7:0] UDC_COUNT_RST   = 8'h00;
	// register byte offsets
	localparam logic [7:0] UDC_OFS_CTRL    = 8'h00;
	localparam logic [7:0] UDC_OFS_PRESET  = 8'h04;
	localparam logic [7:0] UDC_OFS_STATUS  = 8'h08;
	// control register fields
	localparam int         UDC_CTRL_LOAD   = 0;
	localparam int         UDC_CTRL_FREEZE = 1;
	// status register field, then register reset values
	localparam int         UDC_STAT_TC_N   = 8;
	localparam logic [7:0] UDC_PRESET_RST  = 8'h00;
	localparam logic       UDC_FREEZE_RST  = 1'b0;

	typedef enum logic [1:0] {
		UDC_BUS_IDLE = 2'b01,
		UDC_BUS_ACK  = 2'b10
	} udc_bus_state_t;

	typedef struct packed {
		logic        cyc;
		logic        stb;
		logic        we;
		logic [7:0]  adr;
		logic [3:0]  sel;
		logic [31:0] dat;
	} udc_wb_req_t;

	typedef struct packed {
		logic        ack;
		logic [31:0] dat;
	} udc_wb_rsp_t;

	typedef struct packed {
		logic load_n;
		logic count_up;
		logic count_gate_par_n;
		logic count_gate_trickle_n;
	} udc_ctrl_t;
endpackage : udc_pkg

// file: udc_regs.sv
// udc_regs: wishbone slave holding the software control and preset registers
// assumes a classic single-cycle master on clk_i; answers one cycle after request
`timescale 1ns/1ps
module udc_regs
	import udc_pkg::*;
(
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire udc_wb_req_t wb_req_i,
	output udc_wb_rsp_t      wb_rsp_o,
	input  wire logic [7:0]  count_i,
	input  wire logic        tc_n_i,
	output logic [7:0]       sw_preset_o,
	output logic             sw_load_o,
	output logic             sw_freeze_o
);
	udc_bus_state_t state;
	udc_bus_state_t next_state;

	// request decode, one aligned word per register
	wire       req_w    = wb_req_i.cyc & wb_req_i.stb;
	wire       commit_w = req_w & wb_req_i.we & wb_req_i.sel[0] & (state == UDC_BUS_ACK);
	wire       hit_ctrl = wb_req_i.adr == UDC_OFS_CTRL;
	wire       hit_pre  = wb_req_i.adr == UDC_OFS_PRESET;
	wire       hit_stat = wb_req_i.adr == UDC_OFS_STATUS;
	wire [31:0] rd_w    = hit_ctrl ? {30'h0, sw_freeze_o, 1'b0} :
	                      hit_pre  ? {24'h0, sw_preset_o} :
	                      hit_stat ? {23'h0, tc_n_i, count_i} : 32'h0;

	// ack drops after one cycle so a held request is not answered twice
	always_comb begin
		unique case (state)
			UDC_BUS_IDLE: next_state = req_w ? UDC_BUS_ACK : UDC_BUS_IDLE;
			UDC_BUS_ACK:  next_state = UDC_BUS_IDLE;
			default:      next_state = UDC_BUS_IDLE;
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state    <= UDC_BUS_IDLE;
			wb_rsp_o <= '0;
		end else begin
			state        <= next_state;
			wb_rsp_o.ack <= next_state == UDC_BUS_ACK;
			wb_rsp_o.dat <= rd_w;
		end
	end

	// writes land at the edge that the master samples ack; load bit self-clears
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			sw_preset_o <= UDC_PRESET_RST;
			sw_freeze_o <= UDC_FREEZE_RST;
			sw_load_o   <= 1'b0;
		end else begin
			sw_load_o <= commit_w & hit_ctrl & wb_req_i.dat[UDC_CTRL_LOAD];
			if (commit_w & hit_ctrl)
				sw_freeze_o <= wb_req_i.dat[UDC_CTRL_FREEZE];
			if (commit_w & hit_pre)
				sw_preset_o <= wb_req_i.dat[7:0];
		end
	end
endmodule : udc_regs

// file: udc_counter.sv
// udc_counter: synchronous 8-bit up/down binary counter with preset and cascade enables
// assumes pin controls come from logic on clk_i and a classic wishbone master
//
// Function
// - state changes, count or load, only at the rising clock edge
// - eight stages, parallel count outputs and eight parallel preset inputs
// - load low at the edge copies the preset, ignoring direction and enables
// - both enables low: count up when direction high, down when low
// - parallel enable high holds the value whatever the direction
// - trickle enable high holds the value and forces terminal flag high
// - terminal flag low only with trickle enable low at terminal count
// - up terminal is all ones, down terminal is all zeros
//
// Register access over Wishbone and the register offsets were decided locally.
`timescale 1ns/1ps
module udc_counter
	import udc_pkg::*;
(
	input  wire logic                 clk_i,
	input  wire logic                 rst_i,
	input  wire udc_wb_req_t          wb_req_i,
	output udc_wb_rsp_t               wb_rsp_o,
	input  wire udc_ctrl_t            ctl_i,
	input  wire logic [UDC_WIDTH-1:0] preset_in_i,
	output logic [UDC_WIDTH-1:0]      count_out_o,
	output logic                      terminal_flag_n_o
);
	logic [7:0] sw_preset;
	logic       sw_load;
	logic       sw_freeze;
	logic [7:0] next_count;
	logic       next_tc_n;

	// terminal value for the selected direction
	function automatic logic udc_at_term(input logic [7:0] value, input logic up);
		udc_at_term = up ? (value == UDC_TERM_UP) : (value == UDC_TERM_DOWN);
	endfunction : udc_at_term

	udc_regs u_regs (
		.clk_i       (clk_i),
		.rst_i       (rst_i),
		.wb_req_i    (wb_req_i),
		.wb_rsp_o    (wb_rsp_o),
		.count_i     (count_out_o),
		.tc_n_i      (terminal_flag_n_o),
		.sw_preset_o (sw_preset),
		.sw_load_o   (sw_load),
		.sw_freeze_o (sw_freeze)
	);

	// mode decode; the pin load beats the software load, which beats counting
	wire pin_load_w = ~ctl_i.load_n;
	wire enable_w   = ~ctl_i.count_gate_par_n & ~ctl_i.count_gate_trickle_n;
	wire step_w     = ~pin_load_w & ~sw_load & ~sw_freeze & enable_w;
	// 8-bit add and subtract wrap by themselves
	wire [7:0] inc_w = count_out_o + 8'h01;
	wire [7:0] dec_w = count_out_o - 8'h01;

	always_comb begin
		if (pin_load_w)
			next_count = preset_in_i;
		else if (sw_load)
			next_count = sw_preset;
		else if (step_w)
			next_count = ctl_i.count_up ? inc_w : dec_w;
		else
			next_count = count_out_o;
	end

	// flag is registered, so it tracks the count and controls taken at the same edge
	assign next_tc_n = ~(~ctl_i.count_gate_trickle_n & udc_at_term(next_count, ctl_i.count_up));

	// no documented reset; rst_i only gives a defined start before the first load
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			count_out_o       <= UDC_COUNT_RST;
			terminal_flag_n_o <= 1'b1;
		end else begin
			count_out_o       <= next_count;
			terminal_flag_n_o <= next_tc_n;
		end
	end

	// checks on the counter behaviour
	property p_load;
		@(posedge clk_i) disable iff (rst_i)
		!ctl_i.load_n |=> count_out_o == $past(preset_in_i);
	endproperty
	a_load: assert property (p_load) else $error("load did not copy preset");

	property p_count_up;
		@(posedge clk_i) disable iff (rst_i)
		(ctl_i.load_n && !sw_load && !sw_freeze && enable_w && ctl_i.count_up)
			|=> count_out_o == $past(count_out_o) + 8'h01;
	endproperty
	a_count_up: assert property (p_count_up) else $error("count up step wrong");

	property p_count_down;
		@(posedge clk_i) disable iff (rst_i)
		(ctl_i.load_n && !sw_load && !sw_freeze && enable_w && !ctl_i.count_up)
			|=> count_out_o == $past(count_out_o) - 8'h01;
	endproperty
	a_count_down: assert property (p_count_down) else $error("count down step wrong");

	property p_hold_par;
		@(posedge clk_i) disable iff (rst_i)
		(ctl_i.load_n && !sw_load && ctl_i.count_gate_par_n) |=> $stable(count_out_o);
	endproperty
	a_hold_par: assert property (p_hold_par) else $error("moved with parallel enable high");

	property p_hold_trickle;
		@(posedge clk_i) disable iff (rst_i)
		(ctl_i.load_n && !sw_load && ctl_i.count_gate_trickle_n)
			|=> $stable(count_out_o) && terminal_flag_n_o;
	endproperty
	a_hold_trickle: assert property (p_hold_trickle) else $error("trickle hold failed");

	property p_flag_cause;
		@(posedge clk_i) disable iff (rst_i)
		!terminal_flag_n_o |-> !$past(ctl_i.count_gate_trickle_n)
			&& udc_at_term(count_out_o, $past(ctl_i.count_up));
	endproperty
	a_flag_cause: assert property (p_flag_cause) else $error("flag low without cause");

	property p_flag_set;
		@(posedge clk_i) disable iff (rst_i)
		(!ctl_i.count_gate_trickle_n && ctl_i.count_up && next_count == 8'hff)
			|=> !terminal_flag_n_o;
	endproperty
	a_flag_set: assert property (p_flag_set) else $error("flag missed all ones");

	property p_wrap_up;
		@(posedge clk_i) disable iff (rst_i)
		(step_w && ctl_i.count_up && count_out_o == 8'hff) |=> count_out_o == 8'h00;
	endproperty
	a_wrap_up: assert property (p_wrap_up) else $error("no wrap to zero");

	property p_wrap_down;
		@(posedge clk_i) disable iff (rst_i)
		(step_w && !ctl_i.count_up && count_out_o == 8'h00) |=> count_out_o == 8'hff;
	endproperty
	a_wrap_down: assert property (p_wrap_down) else $error("no wrap to all ones");

	property p_edge_only;
		@(posedge clk_i) disable iff (rst_i)
		(ctl_i.load_n && !sw_load && !step_w) |=> count_out_o == $past(count_out_o, 1);
	endproperty
	a_edge_only: assert property (p_edge_only) else $error("count changed without cause");

	// the hold and step checks look at internal decode on purpose:
	// a bench that drives only pins cannot see the software load and freeze,
	// and the load gates every hold check, load and freeze every step check

	// down terminal is all zeros, the twin of the all-ones check
	property p_flag_down;
		@(posedge clk_i) disable iff (rst_i)
		(!ctl_i.count_gate_trickle_n && !ctl_i.count_up && next_count == 8'h00) |=> !terminal_flag_n_o;
	endproperty
	a_flag_down: assert property (p_flag_down) else $error("flag missed all zeros");

	// trickle high forces the flag high whatever else happens
	property p_flag_trickle_high;
		@(posedge clk_i) disable iff (rst_i)
		ctl_i.count_gate_trickle_n |=> terminal_flag_n_o;
	endproperty
	a_flag_trickle_high: assert property (p_flag_trickle_high) else $error("flag low with trickle high");

	// away from the terminal value the flag must be released
	property p_flag_clear;
		@(posedge clk_i) disable iff (rst_i)
		(!ctl_i.count_gate_trickle_n && !udc_at_term(next_count, ctl_i.count_up)) |=> terminal_flag_n_o;
	endproperty
	a_flag_clear: assert property (p_flag_clear) else $error("flag stuck low");

	// loading a terminal value shows the flag straight away
	property p_load_terminal;
		@(posedge clk_i) disable iff (rst_i)
		(!ctl_i.load_n && !ctl_i.count_gate_trickle_n && udc_at_term(preset_in_i, ctl_i.count_up))
			|=> !terminal_flag_n_o;
	endproperty
	a_load_terminal: assert property (p_load_terminal) else $error("flag missed loaded terminal");

	// either gate high stops counting
	property p_gate_hold;
		@(posedge clk_i) disable iff (rst_i)
		(ctl_i.load_n && !sw_load && (ctl_i.count_gate_par_n || ctl_i.count_gate_trickle_n))
			|=> $stable(count_out_o);
	endproperty
	a_gate_hold: assert property (p_gate_hold) else $error("counted with a gate high");

	// a low flag while counting up means every stage is high
	property p_flag_all_ones;
		@(posedge clk_i) disable iff (rst_i)
		(!terminal_flag_n_o && $past(ctl_i.count_up)) |-> count_out_o == 8'hff;
	endproperty
	a_flag_all_ones: assert property (p_flag_all_ones) else $error("up flag off all ones");

	// a low flag while counting down means every stage is low
	property p_flag_all_zeros;
		@(posedge clk_i) disable iff (rst_i)
		(!terminal_flag_n_o && !$past(ctl_i.count_up)) |-> count_out_o == 8'h00;
	endproperty
	a_flag_all_zeros: assert property (p_flag_all_zeros) else $error("down flag off all zeros");

	// load ignores a high trickle gate, which still holds the flag high
	property p_load_trickle;
		@(posedge clk_i) disable iff (rst_i)
		(!ctl_i.load_n && ctl_i.count_gate_trickle_n)
			|=> count_out_o == $past(preset_in_i) && terminal_flag_n_o;
	endproperty
	a_load_trickle: assert property (p_load_trickle) else $error("load with trickle high wrong");

	// a granted step always moves the count
	property p_step_moves;
		@(posedge clk_i) disable iff (rst_i)
		step_w |=> count_out_o != $past(count_out_o);
	endproperty
	a_step_moves: assert property (p_step_moves) else $error("step left count unchanged");

	// parallel hold keeps the flag tied to the held value
	property p_hold_par_flag;
		@(posedge clk_i) disable iff (rst_i)
		(ctl_i.load_n && !sw_load && ctl_i.count_gate_par_n && !ctl_i.count_gate_trickle_n)
			|=> terminal_flag_n_o == !udc_at_term(count_out_o, $past(ctl_i.count_up));
	endproperty
	a_hold_par_flag: assert property (p_hold_par_flag) else $error("flag wrong during hold");
endmodule : udc_counter

// file: udc_next_stage.sv
// udc_next_stage: behavioural next cascaded counter stage on the far side
// assumes the same clk_i and the stage flag wired to its trickle gate
`timescale 1ns/1ps
module udc_next_stage (
	input  wire logic       clk_i,
	input  wire logic       rst_i,
	input  wire logic       trickle_n_i,
	input  wire logic       par_n_i,
	input  wire logic       up_i,
	output logic [7:0]      count_o
);
	// counts only when the previous flag and the common gate are both low
	always_ff @(posedge clk_i) begin
		if (rst_i)
			count_o <= 8'h00;
		else if (!trickle_n_i && !par_n_i)
			count_o <= up_i ? count_o + 8'h01 : count_o - 8'h01;
	end
endmodule : udc_next_stage

// file: test_up_down_binary_counter_8bit.sv
// test_up_down_binary_counter_8bit: directed checks of pins, cascade and registers
// assumes udc_pkg is compiled first and a 10 MHz clock
`timescale 1ns/1ps
module test_up_down_binary_counter_8bit
	import udc_pkg::*;
;
	logic        clk_i;
	logic        rst_i;
	udc_wb_req_t req;
	udc_wb_rsp_t wb_rsp_o;
	udc_ctrl_t   ctl;
	logic [7:0]  pre;
	logic [7:0]  cnt;
	logic        flag_n;
	logic [7:0]  nxt_cnt;
	logic [31:0] rd;
	int          num_errors = 0;
	int          cmp_count = 0;

	udc_counter dut (.clk_i(clk_i), .rst_i(rst_i), .wb_req_i(req), .wb_rsp_o(wb_rsp_o),
		.ctl_i(ctl), .preset_in_i(pre), .count_out_o(cnt), .terminal_flag_n_o(flag_n));
	// next stage shares the parallel gate, as a cascade must
	udc_next_stage nxt (.clk_i(clk_i), .rst_i(rst_i), .trickle_n_i(flag_n),
		.par_n_i(ctl.count_gate_par_n), .up_i(ctl.count_up), .count_o(nxt_cnt));

	initial begin
		clk_i = 1'b0;
		forever #50 clk_i = ~clk_i;
	end

	task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
		cmp_count++;
		if (s !== e) begin
			num_errors++;
			$display("MISMATCH %s expected %h seen %h", nm, e, s);
		end
	endtask : chk

	// control bits: load_n, up, par_n, trickle_n; driven at a rising edge, checked at the falling one
	task automatic apply(input logic [3:0] c, input logic [7:0] p);
		@(posedge clk_i);
		ctl <= c;
		pre <= p;
		@(posedge clk_i);
		// park: count held, direction and trickle kept so the flag stays put
		ctl <= {1'b1, c[2], 1'b1, c[0]};
		@(negedge clk_i);
	endtask : apply

	// classic single cycle; waits on ack as long as it takes, only the watchdog ends a hang
	task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] wd, output logic [31:0] r);
		@(posedge clk_i);
		req <= '{cyc:1'b1, stb:1'b1, we:we, adr:adr, sel:4'h1, dat:wd};
		do begin
			@(posedge clk_i);
		end while (wb_rsp_o.ack !== 1'b1);
		r = wb_rsp_o.dat;
		req <= '0;
	endtask : wb

	task automatic finish_test();
		$display("comparisons %0d mismatches %0d", cmp_count, num_errors);
		if (num_errors == 0 && cmp_count > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : finish_test

	// whole run is some 56 cycles, so 2000 means a hang
	initial begin
		repeat (2000) @(posedge clk_i);
		num_errors++;
		finish_test();
	end

	initial begin
		rst_i = 1'b1;
		ctl = 4'hf;
		pre = 8'h00;
		req = '0;
		repeat (5) @(posedge clk_i);
		rst_i <= 1'b0;
		@(negedge clk_i);
		chk("reset count", cnt, UDC_COUNT_RST);
		chk("reset flag", flag_n, 1'b1);
		$display("test reset done");
		apply(4'b0111, 8'hfe); // load despite gates high
		chk("load", cnt, 8'hfe);
		chk("flag gated", flag_n, 1'b1);
		apply(4'b1100, 8'h00);
		chk("count up", cnt, 8'hff);
		chk("up terminal", flag_n, 1'b0);
		apply(4'b1110, 8'h00);
		chk("par hold", cnt, 8'hff);
		apply(4'b1100, 8'h00);
		chk("wrap up", cnt, 8'h00);
		chk("cascade up", nxt_cnt, 8'h01);
		apply(4'b1001, 8'h00);
		chk("trickle hold", cnt, 8'h00);
		chk("trickle flag", flag_n, 1'b1);
		apply(4'b1010, 8'h00);
		chk("down terminal", flag_n, 1'b0);
		apply(4'b1000, 8'h00);
		chk("wrap down", cnt, 8'hff);
		chk("cascade down", nxt_cnt, 8'h00);
		$display("test pins done");
		@(posedge clk_i);
		ctl <= 4'b1111;
		wb(1'b1, UDC_OFS_PRESET, 32'h5a, rd);
		wb(1'b0, UDC_OFS_PRESET, 32'h0, rd);
		chk("preset rd", rd, 32'h5a);
		wb(1'b1, UDC_OFS_CTRL, 32'h1, rd);
		repeat (2) @(posedge clk_i);
		@(negedge clk_i);
		chk("sw load", cnt, 8'h5a);
		wb(1'b0, UDC_OFS_STATUS, 32'h0, rd);
		chk("status", rd, 32'h15a);
		wb(1'b0, 8'h0c, 32'h0, rd);
		chk("unmapped", rd, 32'h0);
		// software freeze holds counting with both gates low, and reads back
		wb(1'b1, UDC_OFS_CTRL, 32'h2, rd);
		apply(4'b1100, 8'h00);
		chk("freeze hold", cnt, 8'h5a);
		wb(1'b0, UDC_OFS_CTRL, 32'h0, rd);
		chk("ctrl rd", rd, 32'h2);
		wb(1'b1, UDC_OFS_CTRL, 32'h0, rd);
		apply(4'b1100, 8'h00);
		chk("unfreeze", cnt, 8'h5b);
		$display("test registers done");
		// reset again in mid-run: count, flag and preset register go back
		@(posedge clk_i);
		rst_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		@(negedge clk_i);
		chk("rerun count", cnt, UDC_COUNT_RST);
		chk("rerun flag", flag_n, 1'b1);
		wb(1'b0, UDC_OFS_PRESET, 32'h0, rd);
		chk("rerun preset", rd, {24'h0, UDC_PRESET_RST});
		$display("test mid-run reset done");
		finish_test();
	end
endmodule : test_up_down_binary_counter_8bit
